// ---- logic/hrp_port.sv ----
// Purpose: Bus target port for register and API access by the host MCU.
// Assumes: i_link_clk oversamples SCL and SDA; i_clk runs the rest.
// Notes:   Events and answers cross between the clocks by toggle handshakes.
// Function
// - Answer as target at address 0x50, i.e. 0xA0 write, 0xA1 read.
// - Port is idle and releases both lines while the UART owns the pins.
// - Register write: index byte, then data stored at that index unless it is the flag index 0x08, all acked.
// - Each further written byte goes to the next index until STOP.
// - Register read after repeated START returns indexed and following bytes.
// - API call: number, length m, then m input bytes; m zero means none.
// - API execution starts only at the STOP ending the call.
// - Return read first echoes the number of the returned API.
// - Then return length n, then n buffer bytes from index zero.
// - Alert goes high while any event flag is pending.
// - Alert returns low once all event flags are cleared.
// - Port only pulls SCL and SDA low or releases them.
// - Reading the primary event flags clears their event bits.
`timescale 1ns/1ps
`include "hrp_defs.svh"
module hrp_port
	import hrp_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_link_clk,
	input  wire logic       i_scl_i,
	input  wire logic       i_sda_i,
	output logic            o_scl_o,
	output logic            o_scl_oe,
	output logic            o_sda_o,
	output logic            o_sda_oe,
	input  wire logic       i_uart_sel,
	input  wire logic       i_api_mode,
	input  wire logic [7:0] i_event_set,
	input  wire logic [7:0] i_status_lvl,
	input  wire logic [7:0] i_ret_api,
	input  wire logic [7:0] i_ret_len,
	input  wire logic       i_fw_we,
	input  wire logic [7:0] i_fw_addr,
	input  wire logic [7:0] i_fw_wdata,
	output logic      [7:0] o_fw_rdata,
	output logic            o_alert,
	output logic            o_api_start,
	output logic      [7:0] o_api_num,
	output logic      [7:0] o_api_len
);
	localparam logic [7:0] STICKY = `HRP_STICKY_MASK;
	localparam logic [7:0] LEVEL  = `HRP_LEVEL_MASK;
	localparam logic [7:0] FLAG_RST = `HRP_FLAG_RESET;

	function automatic logic is_flag_idx(input logic [7:0] idx);
		return idx == `HRP_FLAG_IDX;
	endfunction

	// ======================================================================
	// Link domain: reset, synchronisers and line events
	logic          lrst_m, lrst;
	logic          scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic          sel_m, sel_s, ack_m, ack_s, ans_m, ans_s;
	logic          ack_tog, ans_tog, evt_tog, ans_want;
	logic [7:0]    ans_data;
	hrp_evt_word_t evt_word, post_word;
	logic          post_req, post_pend, active, rw;
	logic [7:0]    shreg, txsh;
	logic [3:0]    bitcnt;
	hrp_lk_state_t lk_state;

	always_ff @(posedge i_link_clk)
	begin
		lrst_m <= i_sys_rst;
		lrst   <= lrst_m;
	end

	always_ff @(posedge i_link_clk)
	begin
		scl_m <= i_scl_i;
		scl_s <= scl_m;
		scl_d <= scl_s;
		sda_m <= i_sda_i;
		sda_s <= sda_m;
		sda_d <= sda_s;
		sel_m <= i_uart_sel;
		sel_s <= sel_m;
		ack_m <= ack_tog;
		ack_s <= ack_m;
		ans_m <= ans_tog;
		ans_s <= ans_m;
	end

	wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_seen  = scl_s & scl_d & ~sda_d & sda_s;
	wire scl_rise   = scl_s & ~scl_d;
	wire scl_fall   = ~scl_s & scl_d;
	wire chan_free  = (evt_tog == ack_s);
	wire ans_ready  = (ans_want == ans_s);
	// SCL stays stretched until every posted event is taken and, on a
	// read, the next byte is in hand; that is how system stalls reach
	// the host without losing a byte.
	wire go = chan_free & ~post_req & ~post_pend & (~rw | ans_ready);

	// ======================================================================
	// Link domain: bit engine
	always_ff @(posedge i_link_clk)
	begin
		post_req <= 1'b0;
		if (lrst || sel_s)
		begin
			lk_state <= LK_IDLE;
			o_sda_oe <= 1'b0;
			o_scl_oe <= 1'b0;
			active   <= 1'b0;
			rw       <= 1'b0;
			bitcnt   <= 4'h0;
			shreg    <= 8'h00;
			txsh     <= 8'h00;
			post_word <= '{kind: HRP_EV_STOP, data: 8'h00};
		end
		else if (stop_seen)
		begin
			lk_state <= LK_IDLE;
			o_sda_oe <= 1'b0;
			if (active)
			begin
				post_req  <= 1'b1;
				post_word <= '{kind: HRP_EV_STOP, data: 8'h00};
			end
			active <= 1'b0;
		end
		else if (start_seen)
		begin
			lk_state <= LK_ADDR;
			o_sda_oe <= 1'b0;
			bitcnt   <= 4'h0;
		end
		else
		begin
			case (lk_state)
				LK_ADDR, LK_RX:
				begin
					o_scl_oe <= 1'b0;
					if (scl_rise)
					begin
						shreg  <= {shreg[6:0], sda_s};
						bitcnt <= bitcnt + 4'h1;
					end
					else if (scl_fall && bitcnt == 4'h8)
					begin
						if (lk_state == LK_RX)
						begin
							post_req  <= 1'b1;
							post_word <= '{kind: HRP_EV_DATA, data: shreg};
							o_sda_oe  <= 1'b1;
							lk_state  <= LK_ACK;
						end
						else if (shreg[7:1] == `HRP_TARGET_ADDR)
						begin
							post_req  <= 1'b1;
							post_word <= '{kind: HRP_EV_START,
								data: {7'h00, shreg[0]}};
							rw        <= shreg[0];
							active    <= 1'b1;
							o_sda_oe  <= 1'b1;
							lk_state  <= LK_ACK;
						end
						else
							lk_state <= LK_IDLE;
					end
				end
				LK_ACK, LK_HOLD:
				begin
					if ((lk_state == LK_HOLD || scl_fall) && go)
					begin
						// SCL is let go one link clock later, so the first
						// read bit is set up before the host sees the edge.
						bitcnt   <= 4'h0;
						txsh     <= ans_data;
						o_sda_oe <= rw & ~ans_data[7];
						lk_state <= rw ? LK_TX : LK_RX;
					end
					else if (scl_fall)
					begin
						o_sda_oe <= 1'b0;
						o_scl_oe <= 1'b1;
						lk_state <= LK_HOLD;
					end
				end
				LK_TX:
				begin
					o_scl_oe <= 1'b0;
					if (scl_rise)
						bitcnt <= bitcnt + 4'h1;
					else if (scl_fall && bitcnt == 4'h8)
					begin
						o_sda_oe <= 1'b0;
						lk_state <= LK_MACK;
					end
					else if (scl_fall)
					begin
						o_sda_oe <= ~txsh[6];
						txsh     <= {txsh[6:0], 1'b0};
					end
				end
				LK_MACK:
				begin
					if (scl_rise && !sda_s)
					begin
						post_req  <= 1'b1;
						post_word <= '{kind: HRP_EV_RDREQ, data: 8'h00};
						lk_state  <= LK_ACK;
					end
					else if (scl_rise)
						lk_state <= LK_IDLE;
				end
				LK_IDLE:
					o_sda_oe <= 1'b0;
				default:
					lk_state <= LK_IDLE;
			endcase
		end
	end

	// Line outputs are held at zero so the pins are only ever pulled low.
	always_ff @(posedge i_link_clk)
	begin
		o_scl_o <= 1'b0;
		o_sda_o <= 1'b0;
	end

	// ======================================================================
	// Link domain: event channel toward the system clock
	always_ff @(posedge i_link_clk)
	begin
		if (lrst)
		begin
			post_pend <= 1'b0;
			evt_tog   <= 1'b0;
			ans_want  <= 1'b0;
			evt_word  <= '{kind: HRP_EV_STOP, data: 8'h00};
		end
		else if (post_req)
		begin
			post_pend <= 1'b1;
			if (post_word.kind == HRP_EV_RDREQ ||
				(post_word.kind == HRP_EV_START && post_word.data[0]))
				ans_want <= ~ans_want;
		end
		else if (post_pend && chan_free)
		begin
			post_pend <= 1'b0;
			evt_tog   <= ~evt_tog;
			evt_word  <= post_word;
		end
	end

	// ======================================================================
	// System domain: event intake and two-entry buffer
	logic          ev_m, ev_s;
	hrp_evt_word_t fifo [0:1];
	logic          wptr, rptr;
	logic [1:0]    fcnt;
	hrp_sy_state_t sy_state;

	always_ff @(posedge i_clk)
	begin
		ev_m <= evt_tog;
		ev_s <= ev_m;
	end

	wire in_valid  = (ev_s != ack_tog);
	wire in_ready  = (fcnt != 2'h2);
	wire out_valid = (fcnt != 2'h0);
	wire out_ready = (sy_state == SY_IDLE);
	wire push      = in_valid & in_ready;
	wire pop       = out_valid & out_ready;
	hrp_evt_word_t head;
	assign head = fifo[rptr];

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			ack_tog <= 1'b0;
			wptr    <= 1'b0;
			rptr    <= 1'b0;
			fcnt    <= 2'h0;
		end
		else
		begin
			if (push)
			begin
				fifo[wptr] <= evt_word;
				wptr       <= ~wptr;
				ack_tog    <= ~ack_tog;
			end
			if (pop)
				rptr <= ~rptr;
			fcnt <= fcnt + {1'b0, push} - {1'b0, pop};
		end
	end

	// ======================================================================
	// System domain: event flags and alert
	logic [7:0] flags;
	logic       clr_flags;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_flag
			always_ff @(posedge i_clk)
			begin
				if (i_sys_rst)
					flags[gi] <= FLAG_RST[gi];
				else if (STICKY[gi])
					// Only bits that went out in the read are cleared, so an
					// event landing in the read cycle itself is kept.
					flags[gi] <= i_event_set[gi] |
						(flags[gi] & ~(clr_flags & ans_data[gi]));
				else
					flags[gi] <= i_status_lvl[gi] & LEVEL[gi];
			end
		end
	endgenerate

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			o_alert <= 1'b0;
		else
			o_alert <= |(flags & STICKY);
	end

	// ======================================================================
	// System domain: transfer handling
	hrp_mem_if  mem ();
	hrp_phase_t phase;
	logic [7:0] idx, seq, cnt, len;
	logic       is_rd;
	logic [7:0] seq_eff;

	assign is_rd   = (head.kind == HRP_EV_RDREQ) ||
		(head.kind == HRP_EV_START && head.data[0]);
	assign seq_eff = (head.kind == HRP_EV_START) ? 8'h00 : seq;

	always_comb
	begin
		mem.wr    = 1'b0;
		mem.wdata = head.data;
		mem.addr  = {1'b0, idx[6:0]};
		if (i_api_mode && is_rd)
			mem.addr = {1'b1, 7'(seq_eff - 8'h02)};
		else if (i_api_mode)
			mem.addr = {1'b1, cnt[6:0]};
		if (pop && head.kind == HRP_EV_DATA)
			mem.wr = i_api_mode ? (phase == PH_BODY)
				: (phase == PH_BODY && !is_flag_idx(idx));
	end

	always_ff @(posedge i_clk)
	begin
		clr_flags   <= 1'b0;
		o_api_start <= 1'b0;
		if (i_sys_rst)
		begin
			sy_state  <= SY_IDLE;
			phase     <= PH_NONE;
			idx       <= 8'h00;
			seq       <= 8'h00;
			cnt       <= 8'h00;
			len       <= 8'h00;
			ans_tog   <= 1'b0;
			ans_data  <= 8'h00;
			o_api_num <= 8'h00;
			o_api_len <= 8'h00;
		end
		else
		begin
			case (sy_state)
				SY_IDLE:
				begin
					if (pop && is_rd && i_api_mode)
					begin
						seq <= seq_eff + 8'h01;
						if (seq_eff < 8'h02)
						begin
							ans_data <= (seq_eff == 8'h00)
								? i_ret_api : i_ret_len;
							ans_tog  <= ~ans_tog;
						end
						else
							sy_state <= SY_RD;
					end
					else if (pop && is_rd)
					begin
						idx <= idx + 8'h01;
						if (is_flag_idx(idx))
						begin
							ans_data  <= flags;
							clr_flags <= 1'b1;
							ans_tog   <= ~ans_tog;
						end
						else
							sy_state <= SY_RD;
					end
					else if (pop && head.kind == HRP_EV_START)
						phase <= PH_INDEX;
					else if (pop && head.kind == HRP_EV_STOP)
					begin
						// Only a complete call runs; anything short is dropped.
						if (i_api_mode && phase == PH_BODY && cnt == len)
							o_api_start <= 1'b1;
						phase <= PH_NONE;
					end
					else if (pop && head.kind == HRP_EV_DATA)
					begin
						case (phase)
							PH_INDEX:
							begin
								idx       <= head.data;
								o_api_num <= head.data;
								phase     <= i_api_mode ? PH_LEN : PH_BODY;
							end
							PH_LEN:
							begin
								len       <= head.data;
								o_api_len <= head.data;
								cnt       <= 8'h00;
								phase     <= PH_BODY;
							end
							PH_BODY:
							begin
								if (i_api_mode)
									cnt <= cnt + 8'h01;
								else
									idx <= idx + 8'h01;
							end
							default:
								phase <= PH_NONE;
						endcase
					end
				end
				SY_RD:
				begin
					ans_data <= mem.rdata;
					ans_tog  <= ~ans_tog;
					sy_state <= SY_IDLE;
				end
				default:
					sy_state <= SY_IDLE;
			endcase
		end
	end

	hrp_mem u_mem
	(
		.i_clk      (i_clk),
		.host       (mem.mem),
		.i_fw_we    (i_fw_we),
		.i_fw_addr  (i_fw_addr),
		.i_fw_wdata (i_fw_wdata),
		.o_fw_rdata (o_fw_rdata)
	);
endmodule // hrp_port

// ---- inc/hrp_defs.svh ----
// Purpose: Constants of the host register and API port.
// Assumes: Included by bare name wherever a constant is needed.
// Notes:   Offsets are register indices of the byte-wide register space.
`ifndef HRP_DEFS_SVH
`define HRP_DEFS_SVH

// ==========================================================================
// Bus addressing
`define HRP_TARGET_ADDR   7'h50
`define HRP_ADDR_WRITE    8'hA0
`define HRP_ADDR_READ     8'hA1

// ==========================================================================
// Register space layout
`define HRP_FLAG_IDX      8'h08
`define HRP_API_BASE      8'h80
`define HRP_STICKY_MASK   8'h30
`define HRP_LEVEL_MASK    8'hCE
`define HRP_FLAG_RESET    8'h00

`endif

// ---- inc/hrp_pkg.sv ----
// Purpose: Types shared by the host register and API port.
// Assumes: Nothing beyond the constants header.
// Notes:   State codes are one-hot.
package hrp_pkg;

	// ======================================================================
	// Link event kinds and words
	typedef enum logic [1:0]
	{
		HRP_EV_START = 2'h0,
		HRP_EV_DATA  = 2'h1,
		HRP_EV_RDREQ = 2'h2,
		HRP_EV_STOP  = 2'h3
	} hrp_evt_t;

	typedef struct packed
	{
		hrp_evt_t   kind;
		logic [7:0] data;
	} hrp_evt_word_t;

	// ======================================================================
	// State machines
	typedef enum logic [6:0]
	{
		LK_IDLE = 7'h01,
		LK_ADDR = 7'h02,
		LK_ACK  = 7'h04,
		LK_HOLD = 7'h08,
		LK_RX   = 7'h10,
		LK_TX   = 7'h20,
		LK_MACK = 7'h40
	} hrp_lk_state_t;

	typedef enum logic [1:0]
	{
		SY_IDLE = 2'h1,
		SY_RD   = 2'h2
	} hrp_sy_state_t;

	typedef enum logic [3:0]
	{
		PH_NONE  = 4'h1,
		PH_INDEX = 4'h2,
		PH_LEN   = 4'h4,
		PH_BODY  = 4'h8
	} hrp_phase_t;

endpackage

// ---- inc/hrp_mem_if.sv ----
// Purpose: Host-side access port of the register and buffer memory.
// Assumes: Everything on the system clock.
// Notes:   Read data arrive one clock after the address.
`timescale 1ns/1ps
interface hrp_mem_if;
	logic       wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport host (output wr, output addr, output wdata, input rdata);
	modport mem  (input wr, input addr, input wdata, output rdata);
endinterface

// ---- logic/hrp_mem.sv ----
// Purpose: 256-byte store for the register space and the API buffer.
// Assumes: One clock; the host port and firmware port may act together.
// Notes:   A firmware write to the very address the host writes is lost.
`timescale 1ns/1ps
module hrp_mem
(
	input  wire logic       i_clk,
	hrp_mem_if.mem          host,
	input  wire logic       i_fw_we,
	input  wire logic [7:0] i_fw_addr,
	input  wire logic [7:0] i_fw_wdata,
	output logic      [7:0] o_fw_rdata
);
	logic [7:0] store [0:255];

	// ======================================================================
	// Writes and registered reads
	always_ff @(posedge i_clk)
	begin
		if (host.wr)
			store[host.addr] <= host.wdata;
		if (i_fw_we && !(host.wr && host.addr == i_fw_addr))
			store[i_fw_addr] <= i_fw_wdata;
	end

	always_ff @(posedge i_clk)
	begin
		host.rdata <= store[host.addr];
		o_fw_rdata <= store[i_fw_addr];
	end
endmodule // hrp_mem

// ---- verif/hrp_port_properties.sv ----
// Purpose: Concurrent checks on the ports of the host register port.
// Assumes: Bound to hrp_port; system and link clock domains.
// Notes:   Sees only top-level ports.
`timescale 1ns/1ps
module hrp_port_props
(
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_link_clk,
	input  wire logic       i_scl_i,
	input  wire logic       i_uart_sel,
	input  wire logic       i_api_mode,
	input  wire logic [7:0] i_event_set,
	input  wire logic       o_scl_o,
	input  wire logic       o_scl_oe,
	input  wire logic       o_sda_o,
	input  wire logic       o_sda_oe,
	input  wire logic       o_alert,
	input  wire logic       o_api_start
);
	// ======================================================================
	// Helper counters
	logic [7:0] hold_n;
	logic [7:0] uart_n;

	// A stuck stretch would hang the host, so its length is bounded.
	always_ff @(posedge i_link_clk)
	begin
		if (i_sys_rst || !o_scl_oe)
			hold_n <= 8'h00;
		else if (hold_n != 8'hFF)
			hold_n <= hold_n + 8'h01;
	end

	always_ff @(posedge i_link_clk)
	begin
		if (i_sys_rst || !i_uart_sel)
			uart_n <= 8'h00;
		else if (uart_n != 8'h40)
			uart_n <= uart_n + 8'h01;
	end

	// ======================================================================
	// Properties
	lines_low_a: assert property (
		@(posedge i_link_clk) disable iff (i_sys_rst)
		!o_scl_o && !o_sda_o)
		else $error("open-drain output level not low");
	no_start_a: assert property (
		@(posedge i_link_clk) disable iff (i_sys_rst)
		$changed(o_sda_oe) |-> !i_scl_i)
		else $error("data pull changed while clock high");
	stretch_low_a: assert property (
		@(posedge i_link_clk) disable iff (i_sys_rst)
		$rose(o_scl_oe) |-> !i_scl_i)
		else $error("clock pull began while clock high");
	stretch_bound_a: assert property (
		@(posedge i_link_clk) disable iff (i_sys_rst)
		hold_n < 8'hC8)
		else $error("clock held low too long");
	uart_quiet_a: assert property (
		@(posedge i_link_clk) disable iff (i_sys_rst)
		uart_n == 8'h40 |-> !o_sda_oe && !o_scl_oe)
		else $error("lines pulled while serial port owns pins");
	alert_set_a: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		|i_event_set[5:4] |-> ##[1:3] o_alert)
		else $error("alert missing after event");
	start_pulse_a: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		o_api_start |=> !o_api_start)
		else $error("call start longer than one cycle");
	start_mode_a: assert property (
		@(posedge i_clk) disable iff (i_sys_rst)
		o_api_start |-> i_api_mode)
		else $error("call start outside call context");
endmodule // hrp_port_props

bind hrp_port hrp_port_props u_props
(
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk),
	.i_scl_i(i_scl_i), .i_uart_sel(i_uart_sel), .i_api_mode(i_api_mode),
	.i_event_set(i_event_set), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
	.o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_alert(o_alert),
	.o_api_start(o_api_start)
);

// ---- verif/hrp_host_model.sv ----
// Purpose: Bus master model standing for the host microcontroller.
// Assumes: Lines have pull-ups; changes made at system clock falls.
// Notes:   Results are posted on got_ev.
`timescale 1ns/1ps
module hrp_host_model
(
	input  wire logic i_clk,
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_scl_pull,
	output logic      o_sda_pull
);
	logic [8:0] got;
	int         tmo;
	event       got_ev;

	initial
	begin
		o_scl_pull = 1'b0;
		o_sda_pull = 1'b0;
		tmo = 0;
	end

	task automatic gap;
		repeat (3) @(negedge i_clk);
	endtask

	// Stretching is honoured only for a bounded time, then counted.
	task automatic scl_up;
		int n;
		n = 0;
		o_scl_pull = 1'b0;
		while (!i_scl && n < 400)
		begin
			@(negedge i_clk);
			n++;
		end
		if (n == 400)
			tmo++;
	endtask

	task automatic bitx(input logic b, output logic r);
		@(negedge i_clk);
		o_sda_pull = ~b;
		gap();
		scl_up();
		gap();
		r = i_sda;
		o_scl_pull = 1'b1;
	endtask

	task automatic start;
		@(negedge i_clk);
		o_sda_pull = 1'b0;
		gap();
		scl_up();
		gap();
		o_sda_pull = 1'b1;
		gap();
		o_scl_pull = 1'b1;
	endtask

	task automatic stop;
		@(negedge i_clk);
		o_sda_pull = 1'b1;
		gap();
		scl_up();
		gap();
		o_sda_pull = 1'b0;
		gap();
	endtask

	task automatic wr(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		got = {1'b1, 7'h00, ~r};
		->got_ev;
	endtask

	task automatic rd(input logic last);
		logic       r;
		logic [7:0] d;
		for (int i = 7; i >= 0; i--)
		begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(last, r);
		got = {1'b0, d};
		->got_ev;
	endtask
endmodule // hrp_host_model

// ---- verif/hrp_port_tb_top.sv ----
// Purpose: Self-checking bench of the host register port.
// Assumes: Host model drives the bus; bench resolves the wires.
// Notes:   Expected results queue up and are matched in order.
`timescale 1ns/1ps
`include "hrp_defs.svh"
module hrp_port_tb_top;
	logic       clk, lclk, rst, uart, mode, fw_we, h;
	logic       scl_oe, sda_oe, alert, api_start, m_scl, m_sda;
	logic       scl_w, sda_w;
	logic [7:0] ev_set, lvl, ret_api, ret_len, fw_addr, fw_wd, fw_rd;
	logic [7:0] api_num, api_len, num;
	logic [7:0] d[3];
	logic [15:0] seed;
	logic [8:0] exp_q[$];
	logic [8:0] seen_v;
	event       seen_ev;
	int         err_total, checks_done;

	assign scl_w = ~(scl_oe | m_scl);
	assign sda_w = ~(sda_oe | m_sda);

	hrp_port DUT
	(
		.i_clk(clk), .i_sys_rst(rst), .i_link_clk(lclk), .i_scl_i(scl_w),
		.i_sda_i(sda_w), .o_scl_o(), .o_scl_oe(scl_oe), .o_sda_o(),
		.o_sda_oe(sda_oe), .i_uart_sel(uart), .i_api_mode(mode),
		.i_event_set(ev_set), .i_status_lvl(lvl), .i_ret_api(ret_api),
		.i_ret_len(ret_len), .i_fw_we(fw_we), .i_fw_addr(fw_addr),
		.i_fw_wdata(fw_wd), .o_fw_rdata(fw_rd), .o_alert(alert),
		.o_api_start(api_start), .o_api_num(api_num), .o_api_len(api_len)
	);

	hrp_host_model m
	(
		.i_clk(clk), .i_scl(scl_w), .i_sda(sda_w),
		.o_scl_pull(m_scl), .o_sda_pull(m_sda)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		lclk = 1'b0;
		#1.3;
		forever #3 lclk = ~lclk;
	end

	function automatic logic [7:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction

	task automatic check(input string nm, input logic [8:0] seen,
		input logic [8:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cmp(input logic [8:0] v);
		logic [8:0] e;
		e = 'x;
		if (exp_q.size() > 0)
			e = exp_q.pop_front();
		check("result", v, e);
	endtask

	always @(m.got_ev) cmp(m.got);
	always @(seen_ev) cmp(seen_v);

	task automatic see(input logic [8:0] exp, input logic [8:0] v);
		exp_q.push_back(exp);
		seen_v = v;
		->seen_ev;
		@(negedge clk);
	endtask

	task automatic xw(input logic [7:0] b, input logic a);
		exp_q.push_back({1'b1, 7'h00, a});
		m.wr(b);
	endtask

	task automatic xr(input logic [7:0] e, input logic last);
		exp_q.push_back({1'b0, e});
		m.rd(last);
	endtask

	task automatic rd_one(input logic [7:0] idx, input logic [7:0] e);
		m.start();
		xw(8'hA0, 1'b1);
		xw(idx, 1'b1);
		m.start();
		xw(8'hA1, 1'b1);
		xr(e, 1'b1);
		m.stop();
	endtask

	task automatic call(input logic [7:0] len, input int cnt, input logic ok);
		m.start();
		xw(8'hA0, 1'b1);
		xw(num, 1'b1);
		xw(len, 1'b1);
		for (int i = 0; i < cnt; i++)
			xw(d[i], 1'b1);
		m.stop();
		h = 1'b0;
		repeat (60)
		begin
			@(negedge clk);
			if (api_start)
				h = 1'b1;
		end
		see({8'h00, ok}, {8'h00, h});
		if (ok)
			see({1'b0, len}, {1'b0, api_len});
	endtask

	task automatic fww(input logic [7:0] a, input logic [7:0] v);
		fw_we = 1'b1;
		fw_addr = a;
		fw_wd = v;
		@(negedge clk);
		fw_we = 1'b0;
		@(negedge clk);
	endtask

	task automatic summarize;
		err_total += m.tmo + exp_q.size();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		#2000000;
		err_total++;
		summarize();
	end

	initial
	begin
		{rst, uart, mode, fw_we} = 4'hF & 4'h8;
		{ev_set, lvl, ret_api, ret_len, fw_addr, fw_wd} = 48'h0;
		seed = 16'hA3AD;
		err_total = 0;
		checks_done = 0;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		foreach (d[i])
			d[i] = rnd();
		m.start();
		xw(8'hA0, 1'b1);
		xw(8'h10, 1'b1);
		foreach (d[i])
			xw(d[i], 1'b1);
		m.stop();
		m.start();
		xw(8'hA2, 1'b0);
		xw(8'h10, 1'b0);
		xw(8'h5A, 1'b0);
		m.stop();
		m.start();
		xw(8'hA0, 1'b1);
		xw(8'h10, 1'b1);
		m.start();
		xw(8'hA1, 1'b1);
		xr(d[0], 1'b0);
		xr(d[1], 1'b0);
		xr(d[2], 1'b1);
		m.stop();
		$display("test register access done");
		lvl = rnd() & `HRP_LEVEL_MASK;
		ev_set = 8'h30;
		@(negedge clk);
		ev_set = 8'h00;
		repeat (3) @(negedge clk);
		see(9'h001, {8'h00, alert});
		rd_one(8'h08, lvl | 8'h30);
		repeat (8) @(negedge clk);
		see(9'h000, {8'h00, alert});
		rd_one(8'h08, lvl);
		$display("test event flags done");
		// Let the last STOP reach the system side before the mode changes.
		repeat (20) @(negedge clk);
		mode = 1'b1;
		num = rnd();
		call(8'h02, 2, 1'b1);
		see({1'b0, num}, {1'b0, api_num});
		fw_addr = 8'h81;
		repeat (2) @(negedge clk);
		see({1'b0, d[1]}, {1'b0, fw_rd});
		call(8'h00, 0, 1'b1);
		call(8'h02, 1, 1'b0);
		foreach (d[i])
			d[i] = rnd();
		fww(8'h80, d[0]);
		fww(8'h81, d[1]);
		ret_api = num;
		ret_len = 8'h02;
		m.start();
		xw(8'hA0, 1'b1);
		xw(num, 1'b1);
		m.start();
		xw(8'hA1, 1'b1);
		xr(num, 1'b0);
		xr(8'h02, 1'b0);
		xr(d[0], 1'b0);
		xr(d[1], 1'b1);
		m.stop();
		repeat (20) @(negedge clk);
		mode = 1'b0;
		$display("test api transfers done");
		uart = 1'b1;
		repeat (4) @(negedge clk);
		m.start();
		xw(8'hA0, 1'b0);
		m.stop();
		uart = 1'b0;
		repeat (4) @(negedge clk);
		$display("test shared pins done");
		summarize();
	end
endmodule // hrp_port_tb_top
